// File: tb/drive_model.sv
// Behavioural flexible disk drive: index detector, write sink, read playback
`timescale 1ns/1ps
module drive_model (
  // Clock
  input wire logic core_clk,
  // Control from the bench
  input wire logic spin,
  input wire logic hold,
  input wire logic [31:0] rev,
  // Index detector
  output logic index_in,
  // Write path
  output logic wr_ready,
  // Read path
  output logic [7:0] rd_byte,
  output logic rd_mark,
  output logic rd_valid
);
  integer seed = 32'hee7d104a;
  int cnt = 0;

  initial begin
    index_in = 1'b0;
    wr_ready = 1'b0;
    rd_byte = 8'h00;
    rd_mark = 1'b0;
    rd_valid = 1'b0;
  end

  // ----------------------------------------------------------------
  // Index hole, four cycles wide
  // ----------------------------------------------------------------
  task automatic index_pulse();
    index_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    index_in <= 1'b0;
  endtask

  // Spinning disk: a hole at once, then one per revolution
  always @(posedge core_clk) begin
    if (!spin) begin
      if (cnt != 0) index_in <= 1'b0;
      cnt <= 0;
    end else begin
      cnt <= (cnt >= rev - 1) ? 0 : cnt + 1;
      index_in <= (cnt < 4);
    end
  end

  // Write path stalls at random and for as long as hold asks
  always @(posedge core_clk) begin
    wr_ready <= !hold && (($random(seed) & 7) != 0);
  end

  // ----------------------------------------------------------------
  // Read separator: one strobe per byte
  // ----------------------------------------------------------------
  task automatic play(input logic m, input logic [7:0] b);
    @(posedge core_clk);
    rd_byte <= b;
    rd_mark <= m;
    rd_valid <= 1'b1;
    @(posedge core_clk);
    rd_valid <= 1'b0;
    rd_mark <= ~m;
    // Between strobes the separator output is not the last byte
    rd_byte <= ~b;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// File: tb/test_floppy_track_sector_formatter.sv
// Self-checking bench for the track formatter
`timescale 1ns/1ps
module test_floppy_track_sector_formatter import fmt_pkg::*;;
  logic core_clk, nrst, fmt_start, fmt_head, fmt_busy, fmt_done, fmt_reject, drive_ready;
  logic data_valid, data_ready, wr_mark, wr_valid, wr_ready, rd_mark, rd_valid, index_in;
  logic search_start, search_found, search_error, spin, hold, hd;
  logic [5:0] fmt_track, want_track;
  logic [2:0] want_sector;
  logic [7:0] data_in, wr_byte, rd_byte;
  logic [31:0] rev;
  logic [8:0] expq[$];
  logic [8:0] held;
  logic [7:0] dbuf[0:4095];
  int evq[$];
  integer seed = 32'hee7d104a;
  int miscompares = 0;
  int n_tests = 0;
  int k = 0;
  bit feed = 1'b0;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  floppy_track_sector_formatter floppy_track_sector_formatter_i (.core_clk(core_clk),
    .nrst(nrst), .index_in(index_in), .fmt_start(fmt_start), .fmt_track(fmt_track),
    .fmt_head(fmt_head), .fmt_busy(fmt_busy), .fmt_done(fmt_done), .fmt_reject(fmt_reject),
    .drive_ready(drive_ready), .data_in(data_in), .data_valid(data_valid),
    .data_ready(data_ready), .wr_byte(wr_byte), .wr_mark(wr_mark), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_byte(rd_byte), .rd_mark(rd_mark), .rd_valid(rd_valid),
    .search_start(search_start), .want_track(want_track), .want_sector(want_sector),
    .search_found(search_found), .search_error(search_error));

  drive_model drive_model_i (.core_clk(core_clk), .spin(spin), .hold(hold), .rev(rev),
    .index_in(index_in), .wr_ready(wr_ready), .rd_byte(rd_byte), .rd_mark(rd_mark),
    .rd_valid(rd_valid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic put(input logic m, input logic [7:0] b, input int n);
    repeat (n) expq.push_back({m, b});
  endtask

  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  // A byte either goes on the expected write list or out of the read separator
  task automatic field(input logic m, input logic [7:0] b, input bit rd, inout logic [15:0] c);
    c = crc8(c, b);
    if (rd) drive_model_i.play(m, b);
    else put(m, b, 1);
  endtask

  task automatic emit_crc(input logic [15:0] c, input bit rd);
    logic [15:0] x;
    x = c;
    field(1'b0, c[15:8], rd, x);
    field(1'b0, c[7:0], rd, x);
  endtask

  task automatic label(input logic [7:0] t, h, s, input bit rd, input logic [15:0] flip);
    logic [15:0] c;
    c = CRC_INIT;
    field(1'b1, SECTOR_LABEL_MARK, rd, c);
    field(1'b0, t, rd, c);
    field(1'b0, h, rd, c);
    field(1'b0, s, rd, c);
    field(1'b0, LEN_CODE_512, rd, c);
    emit_crc(c ^ flip, rd);
  endtask

  task automatic build_track(input logic [5:0] t, input logic h);
    logic [15:0] c;
    put(1'b0, FILL_BYTE, int'(PRE_INDEX_FILL_LEN));
    put(1'b0, SYNC_BYTE, int'(SYNC_LEN));
    put(1'b1, TRACK_START_MARK, 1);
    put(1'b0, FILL_BYTE, int'(GAP1_LEN));
    for (int s = 1; s <= 8; s++) begin
      put(1'b0, SYNC_BYTE, int'(SYNC_LEN));
      label({2'b00, t}, {7'h00, h}, 8'(s), 1'b0, 16'h0000);
      put(1'b0, FILL_BYTE, int'(GAP2_LEN));
      put(1'b0, SYNC_BYTE, int'(SYNC_LEN));
      c = CRC_INIT;
      field(1'b1, DATA_MARK, 1'b0, c);
      for (int j = 0; j < int'(DATA_LEN); j++) field(1'b0, dbuf[(s - 1) * 512 + j], 1'b0, c);
      emit_crc(c, 1'b0);
      if (s < 8) put(1'b0, FILL_BYTE, int'(GAP3_LEN));
    end
  endtask

  task automatic cmd(input bit srch, input logic [5:0] t);
    fmt_track <= t;
    want_track <= t;
    fmt_start <= !srch;
    search_start <= srch;
    @(posedge core_clk);
    fmt_start <= 1'b0;
    search_start <= 1'b0;
  endtask

  task automatic wait_ev(input int lim);
    int n;
    n = 0;
    while (evq.size() != 0 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (evq.size() != 0) begin
      miscompares++;
      $display("mismatch event timeout expected %0d seen none", evq[0]);
      final_report();
    end
  endtask

  // ----------------------------------------------------------------
  // Host data feeder and result watcher
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (data_valid && data_ready) k = k + 1;
    if (!(data_valid && !data_ready)) begin
      data_in <= dbuf[k % 4096];
      data_valid <= feed && k < 4096 && (($random(seed) & 3) != 0);
    end
  end

  always @(posedge core_clk) begin
    if (nrst && wr_valid && wr_ready) begin
      if (expq.size() != 0) chk("write word", 16'(expq.pop_front()), {7'h00, wr_mark, wr_byte});
      else chk("end fill", {8'h00, FILL_BYTE}, {7'h00, wr_mark, wr_byte});
    end
    if (nrst && (fmt_reject || fmt_done || search_found || search_error))
      chk("event", (evq.size() != 0) ? 16'(evq.pop_front()) : 16'h0000,
          {12'h000, search_error, search_found, fmt_done, fmt_reject});
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, fmt_start, fmt_head, data_valid, search_start, spin, hold} = 7'h00;
    fmt_track = 6'h00;
    want_track = 6'h00;
    want_sector = 3'h0;
    data_in = 8'h00;
    rev = 32'd25000;
    for (int i = 0; i < 4096; i++) dbuf[i] = 8'($random(seed));
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    evq.push_back(1);
    cmd(1'b0, 6'h05);
    wait_ev(10);
    evq.push_back(8);
    cmd(1'b1, 6'h05);
    wait_ev(10);
    drive_model_i.index_pulse();
    repeat (3) @(posedge core_clk);
    chk("ready after one index", 16'h0000, 16'(drive_ready));
    drive_model_i.index_pulse();
    repeat (3) @(posedge core_clk);
    chk("ready after two", 16'h0001, 16'(drive_ready));
    evq.push_back(1);
    cmd(1'b0, 6'h28);
    wait_ev(10);
    $display("test ready and refusal done");
    // Last track, random head: every field of a whole track, with stalls
    hd = 1'($random(seed));
    build_track(6'h27, hd);
    evq.push_back(2);
    fmt_head <= hd;
    cmd(1'b0, 6'h27);
    feed <= 1'b1;
    spin <= 1'b1;
    repeat (3000) @(posedge core_clk);
    chk("busy while formatting", 16'h0001, 16'(fmt_busy));
    hold <= 1'b1;
    repeat (4) @(posedge core_clk);
    held = {wr_mark, wr_byte};
    repeat (30) @(posedge core_clk);
    chk("stalled valid", 16'h0001, 16'(wr_valid));
    chk("stalled word", 16'(held), {7'h00, wr_mark, wr_byte});
    hold <= 1'b0;
    wait_ev(60000);
    chk("busy after done", 16'h0000, 16'(fmt_busy));
    spin <= 1'b0;
    chk("words left", 16'h0000, 16'(expq.size()));
    chk("data taken", 16'h1000, 16'(k));
    $display("test format done");
    // Wrong sector, then a bad check, then the wanted label
    evq.push_back(4);
    want_sector <= 3'h2;
    cmd(1'b1, 6'h05);
    label(8'h05, 8'h00, 8'h02, 1'b1, 16'h0000);
    label(8'h05, 8'h00, 8'h03, 1'b1, 16'h0001);
    label(8'h05, 8'h00, 8'h03, 1'b1, 16'h0000);
    wait_ev(20);
    evq.push_back(8);
    rev <= 32'd200 + 32'($random(seed) & 63);
    spin <= 1'b1;
    cmd(1'b1, 6'h05);
    wait_ev(1000);
    spin <= 1'b0;
    $display("test search done");
    final_report();
  end
endmodule

// File: verilog/floppy_track_sector_formatter.sv
// Track and sector formatter with record search and drive-ready detect
//
// Behaviour
// - The first index pulse after an accepted format command starts the track; layout begins right after it.
// - Record search aborts with error after one full revolution between index pulses.
// - Drive ready only after two index pulses have been seen.
// - Tracks 00 to 39 are supported; others are refused.
// - Every track holds exactly 8 soft sectors found by label fields.
// - Each sector carries 512 data bytes.
// - Track header after index totals 92 bytes.
// - Header holds one specially encoded track start mark.
// - A gap follows the track start mark up to the label sync.
// - A fixed count of sync bytes precedes every label mark.
// - Each label field starts with one specially encoded label mark.
// - Label address order: track, head, sector, length code.
// - Two check bytes close each label; reads validate with them.
// - A gap separates label check bytes from data sync.
// - Inter-sector gap after data; after sector 8 fill until index.
// - Data mark preceded by 12 sync bytes, then data and two check bytes.
`timescale 1ns/1ps
module floppy_track_sector_formatter import fmt_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Drive index detector
  input wire logic index_in,
  // Format command
  input wire logic fmt_start,
  input wire logic [5:0] fmt_track,
  input wire logic fmt_head,
  output logic fmt_busy,
  output logic fmt_done,
  output logic fmt_reject,
  output logic drive_ready,
  // Sector data from the host
  input wire logic [7:0] data_in,
  input wire logic data_valid,
  output logic data_ready,
  // Write stream to the drive
  output logic [7:0] wr_byte,
  output logic wr_mark,
  output logic wr_valid,
  input wire logic wr_ready,
  // Read stream from the separator
  input wire logic [7:0] rd_byte,
  input wire logic rd_mark,
  input wire logic rd_valid,
  // Record search
  input wire logic search_start,
  input wire logic [5:0] want_track,
  input wire logic [2:0] want_sector,
  output logic search_found,
  output logic search_error
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fmt_state_t st;
    logic [9:0] cnt;
    logic [2:0] sect;
    logic [15:0] crc;
    logic [7:0] hold;
    logic hold_full;
    logic data_ready;
    logic [9:0] took;
    logic [9:0] hdr;
    logic idx_prev;
    logic [1:0] idx_seen;
    logic ready;
    logic [5:0] track;
    logic head;
    logic busy;
    logic done;
    logic reject;
    search_state_t sst;
    logic [1:0] scnt;
    logic [1:0] srev;
    logic [7:0] got_t;
    logic [7:0] got_s;
    logic [15:0] scrc;
    logic [5:0] want_t;
    logic [2:0] want_s;
    logic found;
    logic serr;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic idx_edge;
  logic have;
  logic push;
  logic last;
  logic emit_mark;
  logic [7:0] emit_byte;
  logic [9:0] seg_len;
  logic buf_in_ready;
  logic [BUF_W-1:0] buf_out;

  // ----------------------------------------------------------------
  // CRC-16, polynomial x16+x12+x5+1, MSB first
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      if (x[15] ^ d[i]) begin
        x = {x[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        x = {x[14:0], 1'b0};
      end
    end
    return x;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    idx_edge = index_in && !s_r.idx_prev;
    s_nxt.idx_prev = index_in;
    s_nxt.done = 1'b0;
    s_nxt.reject = 1'b0;
    s_nxt.found = 1'b0;
    s_nxt.serr = 1'b0;

    // Two index pulses prove a diskette is turning
    if (idx_edge && s_r.idx_seen != 2'h2) begin
      s_nxt.idx_seen = s_r.idx_seen + 2'h1;
    end
    s_nxt.ready = (s_nxt.idx_seen == 2'h2);

    // Byte that the current field wants to write
    emit_byte = FILL_BYTE;
    emit_mark = 1'b0;
    have = 1'b1;
    seg_len = ONE_BYTE;
    case (s_r.st)
      FILL: begin
        seg_len = PRE_INDEX_FILL_LEN;
      end
      HDR_SYNC, LBL_SYNC, DAT_SYNC: begin
        emit_byte = SYNC_BYTE;
        seg_len = SYNC_LEN;
      end
      TRACK_MARK: begin
        emit_byte = TRACK_START_MARK;
        emit_mark = 1'b1;
      end
      GAP1: begin
        seg_len = GAP1_LEN;
      end
      LBL_MARK: begin
        emit_byte = SECTOR_LABEL_MARK;
        emit_mark = 1'b1;
      end
      LBL_ADDR: begin
        seg_len = ADDR_LEN;
        case (s_r.cnt[1:0])
          2'h0: emit_byte = {2'h0, s_r.track};
          2'h1: emit_byte = {7'h00, s_r.head};
          2'h2: emit_byte = {5'h00, s_r.sect} + 8'h01;
          default: emit_byte = LEN_CODE_512;
        endcase
      end
      LBL_CRC, DAT_CRC: begin
        seg_len = CRC_LEN;
        emit_byte = s_r.cnt[0] ? s_r.crc[7:0] : s_r.crc[15:8];
      end
      GAP2: begin
        seg_len = GAP2_LEN;
      end
      DAT_MARK: begin
        emit_byte = DATA_MARK;
        emit_mark = 1'b1;
      end
      DAT_BODY: begin
        emit_byte = s_r.hold;
        have = s_r.hold_full;
        seg_len = DATA_LEN;
      end
      GAP3: begin
        seg_len = GAP3_LEN;
      end
      GAP4: begin
        seg_len = ONE_BYTE;
      end
      default: begin
        have = 1'b0;
      end
    endcase

    // A stall by the buffer simply holds the field where it is
    push = have && buf_in_ready;
    last = (s_r.cnt == seg_len - ONE_BYTE);

    if (push) begin
      case (s_r.st)
        LBL_SYNC, DAT_SYNC: s_nxt.crc = CRC_INIT;
        LBL_MARK, LBL_ADDR, DAT_MARK, DAT_BODY: s_nxt.crc = crc_step(s_r.crc, emit_byte);
        default: s_nxt.crc = s_r.crc;
      endcase
      if (s_r.st == DAT_BODY) begin
        s_nxt.hold_full = 1'b0;
      end
      if (s_r.st inside {FILL, HDR_SYNC, TRACK_MARK, GAP1}) begin
        s_nxt.hdr = s_r.hdr + ONE_BYTE;
      end
      s_nxt.cnt = last ? 10'h000 : s_r.cnt + ONE_BYTE;
      if (last) begin
        case (s_r.st)
          FILL: s_nxt.st = HDR_SYNC;
          HDR_SYNC: s_nxt.st = TRACK_MARK;
          TRACK_MARK: s_nxt.st = GAP1;
          GAP1: s_nxt.st = LBL_SYNC;
          LBL_SYNC: s_nxt.st = LBL_MARK;
          LBL_MARK: s_nxt.st = LBL_ADDR;
          LBL_ADDR: s_nxt.st = LBL_CRC;
          LBL_CRC: s_nxt.st = GAP2;
          GAP2: s_nxt.st = DAT_SYNC;
          DAT_SYNC: s_nxt.st = DAT_MARK;
          DAT_MARK: s_nxt.st = DAT_BODY;
          DAT_BODY: s_nxt.st = DAT_CRC;
          DAT_CRC: begin
            s_nxt.st = (s_r.sect == LAST_SECTOR) ? GAP4 : GAP3;
          end
          GAP3: begin
            s_nxt.st = LBL_SYNC;
            s_nxt.sect = s_r.sect + 3'h1;
          end
          default: s_nxt.st = s_r.st;
        endcase
      end
    end

    // Command acceptance and index-driven steps
    case (s_r.st)
      IDLE: begin
        if (fmt_start) begin
          if (!s_r.ready || fmt_track >= TRACK_LIMIT) begin
            s_nxt.reject = 1'b1;
          end else begin
            s_nxt.st = WAIT_INDEX;
            s_nxt.busy = 1'b1;
            s_nxt.track = fmt_track;
            s_nxt.head = fmt_head;
          end
        end
      end
      WAIT_INDEX: begin
        s_nxt.hdr = 10'h000;
        if (idx_edge) begin
          s_nxt.st = FILL;
          s_nxt.cnt = 10'h000;
          s_nxt.sect = 3'h0;
        end
      end
      GAP4: begin
        if (idx_edge) begin
          s_nxt.st = IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // Host data is staged one byte ahead so data_ready stays registered
    if (data_valid && s_r.data_ready) begin
      s_nxt.hold = data_in;
      s_nxt.hold_full = 1'b1;
      s_nxt.took = s_r.took + ONE_BYTE;
    end
    if (s_nxt.st == LBL_SYNC) begin
      s_nxt.took = 10'h000;
    end
    s_nxt.data_ready = (s_nxt.st inside {DAT_SYNC, DAT_MARK, DAT_BODY}) &&
                       !s_nxt.hold_full && (s_nxt.took != DATA_LEN);

    // Record search on the read stream
    case (s_r.sst)
      SEARCH_OFF: begin
        if (search_start) begin
          if (!s_r.ready) begin
            s_nxt.serr = 1'b1;
          end else begin
            s_nxt.sst = HUNT;
            s_nxt.srev = 2'h0;
            s_nxt.want_t = want_track;
            s_nxt.want_s = want_sector;
          end
        end
      end
      HUNT: begin
        if (rd_valid && rd_mark && rd_byte == SECTOR_LABEL_MARK) begin
          s_nxt.sst = READ_ADDR;
          s_nxt.scnt = 2'h0;
          s_nxt.scrc = crc_step(CRC_INIT, rd_byte);
        end
      end
      READ_ADDR: begin
        if (rd_valid) begin
          s_nxt.scrc = crc_step(s_r.scrc, rd_byte);
          s_nxt.scnt = s_r.scnt + 2'h1;
          if (s_r.scnt == 2'h0) begin
            s_nxt.got_t = rd_byte;
          end
          if (s_r.scnt == 2'h2) begin
            s_nxt.got_s = rd_byte;
          end
          if (s_r.scnt == 2'h3) begin
            s_nxt.sst = READ_CRC;
          end
        end
      end
      READ_CRC: begin
        if (rd_valid) begin
          s_nxt.scrc = crc_step(s_r.scrc, rd_byte);
          s_nxt.scnt = s_r.scnt + 2'h1;
          if (s_r.scnt[0]) begin
            s_nxt.sst = HUNT;
            if (s_nxt.scrc == CRC_RESIDUE && s_r.got_t == {2'h0, s_r.want_t} &&
                s_r.got_s == {5'h00, s_r.want_s} + 8'h01) begin
              s_nxt.found = 1'b1;
              s_nxt.sst = SEARCH_OFF;
            end
          end
        end
      end
      default: begin
        s_nxt.sst = SEARCH_OFF;
      end
    endcase

    // Second index since the start means a whole revolution went by
    if (s_r.sst != SEARCH_OFF && !s_nxt.found && idx_edge) begin
      if (s_r.srev == 2'h1) begin
        s_nxt.serr = 1'b1;
        s_nxt.sst = SEARCH_OFF;
      end else begin
        s_nxt.srev = s_r.srev + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer and ports
  // ----------------------------------------------------------------
  fmt_buf u_buf (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_data({emit_mark, emit_byte}),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .out_data(buf_out),
    .out_valid(wr_valid),
    .out_ready(wr_ready)
  );

  assign wr_byte = buf_out[7:0];
  assign wr_mark = buf_out[8];
  assign fmt_busy = s_r.busy;
  assign fmt_done = s_r.done;
  assign fmt_reject = s_r.reject;
  assign drive_ready = s_r.ready;
  assign data_ready = s_r.data_ready;
  assign search_found = s_r.found;
  assign search_error = s_r.serr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence last_sync_s;
    push && last && s_r.st inside {LBL_SYNC, DAT_SYNC};
  endsequence

  sequence crc_done_s;
    push && last && s_r.st == DAT_CRC;
  endsequence

  index_start_a: assert property (
    s_r.st == WAIT_INDEX && idx_edge |=> s_r.st == FILL && s_r.cnt == 10'h000)
    else $error("layout did not start at index");

  search_abort_a: assert property (
    s_r.sst == HUNT && s_r.srev == 2'h1 && idx_edge |=> search_error && s_r.sst == SEARCH_OFF)
    else $error("search not aborted after a revolution");

  ready_rise_a: assert property (
    $rose(drive_ready) |-> $past(idx_edge) && s_r.idx_seen == 2'h2)
    else $error("ready without two index pulses");

  track_refuse_a: assert property (
    s_r.st == IDLE && fmt_start && fmt_track >= TRACK_LIMIT |=> fmt_reject && s_r.st == IDLE)
    else $error("out of range track accepted");

  last_sector_a: assert property (
    crc_done_s |=> (s_r.st == GAP4) == ($past(s_r.sect) == LAST_SECTOR))
    else $error("wrong sector count per track");

  data_length_a: assert property (
    s_r.st == DAT_BODY && push |-> s_r.took <= DATA_LEN && s_r.cnt < DATA_LEN)
    else $error("data field overrun");

  header_total_a: assert property (
    s_r.st == GAP1 && push && last |=> s_r.hdr == HEADER_LEN)
    else $error("track header length wrong");

  mark_flag_a: assert property (
    push && emit_mark |-> s_r.st inside {TRACK_MARK, LBL_MARK, DAT_MARK} && seg_len == ONE_BYTE)
    else $error("special mark outside a mark field");

  sync_then_mark_a: assert property (
    last_sync_s |=> s_r.st inside {LBL_MARK, DAT_MARK} && s_r.cnt == 10'h000)
    else $error("mark not after sync run");

  label_track_a: assert property (
    s_r.st == LBL_MARK && push |=> s_r.st == LBL_ADDR && emit_byte == {2'h0, s_r.track})
    else $error("label does not open with track");

  found_match_a: assert property (
    search_found |-> s_r.got_t == {2'h0, s_r.want_t} && $past(s_r.sst) == READ_CRC)
    else $error("found without matching label");

endmodule

// File: verilog/fmt_buf.sv
// Two-entry output buffer between the formatter and the write path
`timescale 1ns/1ps
module fmt_buf import fmt_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Filling side
  input wire logic [BUF_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [BUF_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  typedef struct packed {
    logic [1:0][BUF_W-1:0] ent;
    logic [1:0] vld;
  } buf_t;

  buf_t b_r;
  buf_t b_nxt;

  // Entry 0 is the head; a word is only accepted while entry 1 is free
  always_comb begin
    b_nxt = b_r;
    if (out_ready && b_r.vld[0]) begin
      b_nxt.ent[0] = b_r.ent[1];
      b_nxt.vld[0] = b_r.vld[1];
      b_nxt.vld[1] = 1'b0;
    end
    if (in_valid && !b_r.vld[1]) begin
      if (!b_nxt.vld[0]) begin
        b_nxt.ent[0] = in_data;
        b_nxt.vld[0] = 1'b1;
      end else begin
        b_nxt.ent[1] = in_data;
        b_nxt.vld[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      b_r <= '0;
    end else begin
      b_r <= b_nxt;
    end
  end

  assign in_ready = !b_r.vld[1];
  assign out_data = b_r.ent[0];
  assign out_valid = b_r.vld[0];

endmodule

// File: verilog/fmt_pkg.sv
// Constants and types shared by the track formatter and its output buffer
package fmt_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam logic [5:0] TRACK_LIMIT = 6'h28;
  localparam logic [2:0] LAST_SECTOR = 3'h7;
  localparam logic [7:0] LEN_CODE_512 = 8'h02;

  // ----------------------------------------------------------------
  // Field lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [9:0] PRE_INDEX_FILL_LEN = 10'h028;
  localparam logic [9:0] SYNC_LEN = 10'h00c;
  localparam logic [9:0] GAP1_LEN = 10'h027;
  localparam logic [9:0] HEADER_LEN = 10'h05c;
  localparam logic [9:0] ADDR_LEN = 10'h004;
  localparam logic [9:0] CRC_LEN = 10'h002;
  localparam logic [9:0] GAP2_LEN = 10'h016;
  localparam logic [9:0] DATA_LEN = 10'h200;
  localparam logic [9:0] GAP3_LEN = 10'h036;
  localparam logic [9:0] ONE_BYTE = 10'h001;

  // ----------------------------------------------------------------
  // Byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] FILL_BYTE = 8'h4e;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] TRACK_START_MARK = 8'hfc;
  localparam logic [7:0] SECTOR_LABEL_MARK = 8'hfe;
  localparam logic [7:0] DATA_MARK = 8'hfb;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // Output stream word: {mark flag, byte}
  localparam int BUF_W = 9;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    IDLE, WAIT_INDEX, FILL, HDR_SYNC, TRACK_MARK, GAP1,
    LBL_SYNC, LBL_MARK, LBL_ADDR, LBL_CRC, GAP2,
    DAT_SYNC, DAT_MARK, DAT_BODY, DAT_CRC, GAP3, GAP4
  } fmt_state_t;

  typedef enum logic [1:0] {
    SEARCH_OFF, HUNT, READ_ADDR, READ_CRC
  } search_state_t;

endpackage
